// ---- verilog/port_cfg_pkg.sv ----
/*
  Constants for the port, filter and gain-loop configuration register slice.
  Assumes an 8-bit register port addressed by byte offset.
*/
package port_cfg_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          SAMPLE_W        = 8;
  localparam logic [7:0]  OFF_STATUS      = 8'h0a;
  localparam logic [7:0]  OFF_RESERVED    = 8'h0b;
  localparam logic [7:0]  OFF_PORT_CFG    = 8'h0c;
  localparam logic [7:0]  OFF_GAIN1       = 8'h0d;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h20;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h21;
  localparam logic [7:0]  RST_PORT_CFG    = 8'hf0;
  localparam logic [7:0]  RST_GAIN1       = 8'h81;
  localparam logic [7:0]  RESERVED_VALUE  = 8'h00;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  localparam int          ST_INPUT_PIN    = 7;
  localparam int          ST_LINK_DATA    = 6;
  localparam int          ST_FIFO_EMPTY   = 1;
  localparam int          ST_FIFO_FULL    = 0;
  localparam int          PC_OUT1_OD      = 7;
  localparam int          PC_OUT1_VAL     = 6;
  localparam int          PC_OUT0_OD      = 5;
  localparam int          PC_OUT0_VAL     = 4;
  localparam int          PC_ROLL_HI      = 2;
  localparam int          PC_ROLL_LO      = 1;
  localparam int          PC_QNEG         = 0;
  localparam int          GL_DC_COMP      = 7;
  localparam int          GL_COEF_HI      = 2;
  localparam int          GL_COEF_LO      = 0;
  localparam logic [1:0]  ROLL_35         = 2'h0;
  localparam logic [1:0]  ROLL_20         = 2'h1;
  // Interrupt bit positions
  localparam int          IRQ_INPUT_CHG   = 0;
  localparam int          IRQ_FIFO_EMPTY  = 1;
  localparam int          IRQ_FIFO_FULL   = 2;
  localparam int          IRQ_W           = 3;
endpackage

// ---- verilog/port_filter_agc_config_regs.sv ----
/*
  Register slice: status byte, reserved byte, port and filter configuration,
  first gain-loop control, plus an interrupt status and mask pair.
  Assumes all inputs synchronous to clk and a single-cycle strobe register port.
*/
// Strobed register access is this design's own decision.
// Function
// - Status bit 7 shows general input pin
// - Bits 7/6 set output one drive, level
// - Bits 5/4 set output zero drive, level
// - Bits 2:1 select roll-off 35/20 percent
// - Bit 0 negates every Q sample
// - Q negation applied after the derotator
// - Gain byte bit 7 enables DC compensation
`timescale 1ns/1ps
`default_nettype none
module port_filter_agc_config_regs (
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  input  wire logic [port_cfg_pkg::ADDR_W-1:0]        regAddr,
  input  wire logic [port_cfg_pkg::DATA_W-1:0]        regWdata,
  input  wire logic                                   regWrite,
  input  wire logic                                   regRead,
  output logic      [port_cfg_pkg::DATA_W-1:0]        regRdata,
  input  wire logic                                   generalInputPin,
  input  wire logic                                   toneLinkDataInput,
  input  wire logic                                   fifoEmpty,
  input  wire logic                                   fifoFull,
  input  wire logic                                   generalOutputOneIn,
  output logic                                        generalOutputOneOut,
  output logic                                        generalOutputOneOe,
  input  wire logic                                   generalOutputZeroIn,
  output logic                                        generalOutputZeroOut,
  output logic                                        generalOutputZeroOe,
  output logic      [1:0]                             rollOffSel,
  output logic                                        dcCompEnable,
  output logic      [2:0]                             gainLoop1Coefficient,
  input  wire logic [port_cfg_pkg::SAMPLE_W-1:0]      derotQIn,
  input  wire logic                                   derotValid,
  output logic      [port_cfg_pkg::SAMPLE_W-1:0]      qSampleOut,
  output logic                                        qSampleValid,
  output logic                                        irq
);
  import port_cfg_pkg::*;

  logic [DATA_W-1:0] portCfg_ff;
  logic [DATA_W-1:0] gain1_ff;
  logic [IRQ_W-1:0]  irqStatus_ff;
  logic [IRQ_W-1:0]  irqMask_ff;
  logic              inputPrev_ff;
  logic              emptyPrev_ff;
  logic              fullPrev_ff;
  logic [IRQ_W-1:0]  events;
  logic [IRQ_W-1:0]  nxt_irqStatus;
  logic [DATA_W-1:0] statusByte;
  logic [DATA_W-1:0] nxt_rdata;
  logic [SAMPLE_W-1:0] nxt_q;

  wire wrPortCfg = regWrite && (regAddr == OFF_PORT_CFG);
  wire wrGain1   = regWrite && (regAddr == OFF_GAIN1);
  wire wrIrqSt   = regWrite && (regAddr == OFF_IRQ_STATUS);
  wire wrIrqMask = regWrite && (regAddr == OFF_IRQ_MASK);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      portCfg_ff <= RST_PORT_CFG;
    end else if (wrPortCfg) begin
      portCfg_ff <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gain1_ff <= RST_GAIN1;
    end else if (wrGain1) begin
      gain1_ff <= regWdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin and loop controls
  // ----------------------------------------------------------------
  // Open drain: drive low only; push-pull: always drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      generalOutputOneOut  <= RST_PORT_CFG[PC_OUT1_VAL];
      generalOutputOneOe   <= 1'b0;
      generalOutputZeroOut <= RST_PORT_CFG[PC_OUT0_VAL];
      generalOutputZeroOe  <= 1'b0;
    end else begin
      generalOutputOneOut  <= portCfg_ff[PC_OUT1_VAL];
      generalOutputOneOe   <= !portCfg_ff[PC_OUT1_OD] || !portCfg_ff[PC_OUT1_VAL];
      generalOutputZeroOut <= portCfg_ff[PC_OUT0_VAL];
      generalOutputZeroOe  <= !portCfg_ff[PC_OUT0_OD] || !portCfg_ff[PC_OUT0_VAL];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rollOffSel           <= ROLL_35;
      dcCompEnable         <= RST_GAIN1[GL_DC_COMP];
      gainLoop1Coefficient <= RST_GAIN1[GL_COEF_HI:GL_COEF_LO];
    end else begin
      rollOffSel           <= portCfg_ff[PC_ROLL_HI:PC_ROLL_LO];
      dcCompEnable         <= gain1_ff[GL_DC_COMP];
      gainLoop1Coefficient <= gain1_ff[GL_COEF_HI:GL_COEF_LO];
    end
  end

  // ----------------------------------------------------------------
  // Q channel after derotation
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = derotQIn;
    if (portCfg_ff[PC_QNEG]) begin
      nxt_q = SAMPLE_W'(-derotQIn);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      qSampleOut   <= '0;
      qSampleValid <= 1'b0;
    end else begin
      qSampleOut   <= nxt_q;
      qSampleValid <= derotValid;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Unreset: tracks pins through reset, no false edge
  always_ff @(posedge clk) begin
    inputPrev_ff <= generalInputPin;
    emptyPrev_ff <= fifoEmpty;
    fullPrev_ff  <= fifoFull;
  end

  always_comb begin
    events                 = '0;
    events[IRQ_INPUT_CHG]  = generalInputPin != inputPrev_ff;
    events[IRQ_FIFO_EMPTY] = fifoEmpty && !emptyPrev_ff;
    events[IRQ_FIFO_FULL]  = fifoFull && !fullPrev_ff;
  end

  // Set wins over a write-one clear
  always_comb begin
    nxt_irqStatus = (irqStatus_ff & ~(wrIrqSt ? regWdata[IRQ_W-1:0] : '0)) | events;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqStatus_ff <= '0;
    end else begin
      irqStatus_ff <= nxt_irqStatus;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqMask_ff <= '0;
    end else if (wrIrqMask) begin
      irqMask_ff <= regWdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_irqStatus & irqMask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    statusByte                = '0;
    statusByte[ST_INPUT_PIN]  = generalInputPin;
    statusByte[ST_LINK_DATA]  = toneLinkDataInput;
    statusByte[ST_FIFO_EMPTY] = fifoEmpty;
    statusByte[ST_FIFO_FULL]  = fifoFull;
  end

  always_comb begin
    case (regAddr)
      OFF_STATUS:     nxt_rdata = statusByte;
      OFF_RESERVED:   nxt_rdata = RESERVED_VALUE;
      OFF_PORT_CFG:   nxt_rdata = portCfg_ff;
      OFF_GAIN1:      nxt_rdata = gain1_ff;
      OFF_IRQ_STATUS: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irqStatus_ff};
      OFF_IRQ_MASK:   nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irqMask_ff};
      default:        nxt_rdata = UNMAPPED_VALUE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdata <= '0;
    end else if (regRead) begin
      regRdata <= nxt_rdata;
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_status_pin;
    @(posedge clk) disable iff (!rstn)
      regRead && regAddr == OFF_STATUS |=> regRdata[ST_INPUT_PIN] == $past(generalInputPin);
  endproperty
  a_status_pin: assert property (p_status_pin) else $error("input pin bit wrong");

  property p_out1;
    @(posedge clk) disable iff (!rstn)
      wrPortCfg |-> ##2 generalOutputOneOut == $past(regWdata[PC_OUT1_VAL], 2)
        && generalOutputOneOe == !($past(regWdata[PC_OUT1_OD], 2)
        && $past(regWdata[PC_OUT1_VAL], 2));
  endproperty
  a_out1: assert property (p_out1) else $error("output one drive wrong");

  property p_out0;
    @(posedge clk) disable iff (!rstn)
      wrPortCfg |-> ##2 generalOutputZeroOut == $past(regWdata[PC_OUT0_VAL], 2)
        && generalOutputZeroOe == !($past(regWdata[PC_OUT0_OD], 2)
        && $past(regWdata[PC_OUT0_VAL], 2));
  endproperty
  a_out0: assert property (p_out0) else $error("output zero drive wrong");

  property p_roll;
    @(posedge clk) disable iff (!rstn)
      wrPortCfg ##1 !wrPortCfg |=> rollOffSel == $past(regWdata[PC_ROLL_HI:PC_ROLL_LO], 2);
  endproperty
  a_roll: assert property (p_roll) else $error("roll-off select wrong");

  property p_qneg;
    @(posedge clk) disable iff (!rstn)
      portCfg_ff[PC_QNEG] |=> qSampleOut == SAMPLE_W'(-$past(derotQIn));
  endproperty
  a_qneg: assert property (p_qneg) else $error("Q not negated");

  property p_dc;
    @(posedge clk) disable iff (!rstn)
      wrGain1 ##1 !wrGain1 |=> dcCompEnable == $past(regWdata[GL_DC_COMP], 2);
  endproperty
  a_dc: assert property (p_dc) else $error("DC compensation enable wrong");

  property p_coef;
    @(posedge clk) disable iff (!rstn)
      wrGain1 |-> ##2 gainLoop1Coefficient == $past(regWdata[GL_COEF_HI:GL_COEF_LO], 2);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient wrong");

  property p_fifo_flags;
    @(posedge clk) disable iff (!rstn)
      regRead && regAddr == OFF_STATUS |=>
        regRdata[ST_FIFO_EMPTY] == $past(fifoEmpty) && regRdata[ST_FIFO_FULL] == $past(fifoFull)
        && regRdata[ST_LINK_DATA] == $past(toneLinkDataInput);
  endproperty
  a_fifo_flags: assert property (p_fifo_flags) else $error("status flags wrong");

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
      regRead && regAddr == OFF_RESERVED |=> regRdata == RESERVED_VALUE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte not constant");

  property p_ro_write;
    @(posedge clk) disable iff (!rstn)
      regWrite && (regAddr == OFF_STATUS || regAddr == OFF_RESERVED) |=>
        $stable(portCfg_ff) && $stable(gain1_ff);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  property p_cfg_read;
    @(posedge clk) disable iff (!rstn)
      wrPortCfg ##1 (regRead && regAddr == OFF_PORT_CFG && !wrPortCfg) |=>
        regRdata == $past(regWdata, 2);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

  property p_qpass;
    @(posedge clk) disable iff (!rstn)
      !portCfg_ff[PC_QNEG] |=> qSampleOut == $past(derotQIn);
  endproperty
  a_qpass: assert property (p_qpass) else $error("Q changed without negation");

  property p_qvalid;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> qSampleValid == $past(derotValid);
  endproperty
  a_qvalid: assert property (p_qvalid) else $error("Q valid misaligned");

  property p_pad1;
    @(posedge clk) disable iff (!rstn)
      generalOutputOneOe |-> generalOutputOneIn == generalOutputOneOut;
  endproperty
  a_pad1: assert property (p_pad1) else $error("output one pad level wrong");

  property p_pad0;
    @(posedge clk) disable iff (!rstn)
      generalOutputZeroOe |-> generalOutputZeroIn == generalOutputZeroOut;
  endproperty
  a_pad0: assert property (p_pad0) else $error("output zero pad level wrong");

  // ----------------------------------------------------------------
  // Bus and interrupt checks
  // ----------------------------------------------------------------
  property p_rdata_idle;
    @(posedge clk) disable iff (!rstn)
      !regRead |=> regRdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_set_wins;
    @(posedge clk) disable iff (!rstn)
      (|events) |=> (irqStatus_ff & $past(events)) == $past(events);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  property p_clear;
    @(posedge clk) disable iff (!rstn)
      wrIrqSt && events == '0 |=> (irqStatus_ff & $past(regWdata[IRQ_W-1:0])) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("write-one clear failed");

  property p_irq_level;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> irq == |(irqStatus_ff & $past(irqMask_ff));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  c_qneg:  cover property (@(posedge clk) disable iff (!rstn) portCfg_ff[PC_QNEG] && derotValid);
  c_od1:   cover property (@(posedge clk) disable iff (!rstn) !generalOutputOneOe && rstn);
  c_irq:   cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
  c_roll:  cover property (@(posedge clk) disable iff (!rstn) rollOffSel == ROLL_20);
  c_clr_set: cover property (@(posedge clk) disable iff (!rstn) wrIrqSt && (|events));
endmodule
`default_nettype wire

// ---- verification/test_port_filter_agc_config_regs.sv ----
/*
  Self-checking bench for the port, filter and gain-loop register slice.
  Assumes port_cfg_pkg, a 100 MHz clock and pull-ups on both output pins.
*/
`timescale 1ns/1ps
`default_nettype none
module test_port_filter_agc_config_regs;
  import port_cfg_pkg::*;
  logic       clk;
  logic       rstn;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdata;
  logic       generalInputPin;
  logic       toneLinkDataInput;
  logic       fifoEmpty;
  logic       fifoFull;
  logic       oneOut;
  logic       oneOe;
  logic       zeroOut;
  logic       zeroOe;
  logic [1:0] rollOffSel;
  logic       dcCompEnable;
  logic [2:0] gainLoop1Coefficient;
  logic [7:0] derotQIn;
  logic       derotValid;
  logic [7:0] qSampleOut;
  logic       qSampleValid;
  logic       irq;
  wire logic  onePin;
  wire logic  zeroPin;
  int         num_errors;
  int         checks;
  logic [7:0] cfgList [4] = '{8'h00, 8'h52, 8'ha0, 8'hf1};

  // Pin level with pull-up when released
  assign onePin  = oneOe ? oneOut : 1'b1;
  assign zeroPin = zeroOe ? zeroOut : 1'b1;

  port_filter_agc_config_regs dut_u (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .generalInputPin(generalInputPin), .toneLinkDataInput(toneLinkDataInput),
    .fifoEmpty(fifoEmpty), .fifoFull(fifoFull),
    .generalOutputOneIn(onePin), .generalOutputOneOut(oneOut),
    .generalOutputOneOe(oneOe), .generalOutputZeroIn(zeroPin),
    .generalOutputZeroOut(zeroOut), .generalOutputZeroOe(zeroOe),
    .rollOffSel(rollOffSel), .dcCompEnable(dcCompEnable),
    .gainLoop1Coefficient(gainLoop1Coefficient), .derotQIn(derotQIn),
    .derotValid(derotValid), .qSampleOut(qSampleOut),
    .qSampleValid(qSampleValid), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock, tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata & m, e);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic [7:0] c);
    chk({oneOe, oneOut, zeroOe, zeroOut, 1'b0, rollOffSel, 1'b0},
        {c[7] ? ~c[6] : 1'b1, c[6], c[5] ? ~c[4] : 1'b1, c[4], 1'b0, c[2:1], 1'b0});
  endtask

  task automatic qchk(input logic [7:0] x, input logic neg);
    @(posedge clk);
    derotQIn   <= x;
    derotValid <= 1'b1;
    @(posedge clk);
    derotValid <= 1'b0;
    #1;
    chk(qSampleOut, neg ? 8'h00 - x : x);
    chk({7'h00, qSampleValid}, 8'h01);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; regAddr = 8'h00; regWdata = 8'h00; regWrite = 1'b0; regRead = 1'b0;
    generalInputPin = 1'b0; toneLinkDataInput = 1'b0; fifoEmpty = 1'b0; fifoFull = 1'b0;
    derotQIn = 8'h00; derotValid = 1'b0; num_errors = 0; checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdchk(OFF_PORT_CFG, 8'hff, RST_PORT_CFG);
    rdchk(OFF_GAIN1, 8'hff, RST_GAIN1);
    pins(RST_PORT_CFG);
    chk({dcCompEnable, 4'h0, gainLoop1Coefficient}, RST_GAIN1);
    chk({7'h00, irq}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      generalInputPin   <= i[3];
      toneLinkDataInput <= i[2];
      fifoEmpty         <= i[1];
      fifoFull          <= i[0];
      wr(OFF_STATUS, 8'h3c);
      rdchk(OFF_STATUS, 8'hc3, {i[3], i[2], 4'h0, i[1], i[0]});
    end
    $display("test status done");
    wr(OFF_RESERVED, 8'h5a);
    rdchk(OFF_RESERVED, 8'hff, RESERVED_VALUE);
    wr(8'h40, 8'h77);
    rdchk(8'h40, 8'hff, UNMAPPED_VALUE);
    rdchk(OFF_PORT_CFG, 8'hff, RST_PORT_CFG);
    $display("test reserved done");
    foreach (cfgList[k]) begin
      wr(OFF_PORT_CFG, cfgList[k]);
      settle();
      pins(cfgList[k]);
      rdchk(OFF_PORT_CFG, 8'hff, cfgList[k]);
      qchk(8'h05, cfgList[k][0]);
      qchk(8'h80, cfgList[k][0]);
    end
    $display("test port config done");
    wr(OFF_GAIN1, 8'h05);
    settle();
    chk({dcCompEnable, 4'h0, gainLoop1Coefficient}, 8'h05);
    wr(OFF_GAIN1, 8'h86);
    rdchk(OFF_GAIN1, 8'hff, 8'h86);
    settle();
    chk(regRdata, 8'h00);
    chk({dcCompEnable, 4'h0, gainLoop1Coefficient}, 8'h86);
    $display("test gain loop done");
    rdchk(OFF_IRQ_STATUS, 8'h07, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(OFF_IRQ_MASK, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h00);
    rdchk(OFF_IRQ_STATUS, 8'h07, 8'h05);
    @(posedge clk);
    fifoEmpty <= 1'b0;
    @(posedge clk);
    fifoEmpty <= 1'b1;
    repeat (2) settle();
    chk({7'h00, irq}, 8'h01);
    wr(OFF_IRQ_MASK, 8'h00);
    settle();
    chk({7'h00, irq}, 8'h00);
    wr(OFF_IRQ_STATUS, 8'h07);
    rdchk(OFF_IRQ_STATUS, 8'h07, 8'h00);
    $display("test interrupt done");
    summarize();
  end

  // Hang guard, far beyond the under two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
